// ==== dv/qtm_aux_src.sv ====
// auxiliary input source standing in for external pulse and event signals
module qtm_aux_src (
    input  wire logic clk,
    output logic      line
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************
    // level and toggle driver
    // ****************
    initial line = 1'b0;

    // n of zero sets a level; otherwise n toggles spaced gap clocks, at least 4
    task automatic drive(input int n, input logic v, input int gap);
        if (n == 0) begin
            @(posedge clk);
            line <= v;
        end
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            line <= ~line;
            repeat ((gap < 4 ? 4 : gap) - 1) @(posedge clk);
        end
    endtask
endmodule

// ==== dv/qtm_top_props.sv ====
// concurrent checks on the quad timer ports, bound to the top module
module qtm_top_props (
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic [5:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       TIMER_A_AUX_INPUT,
    input wire logic       TIMER_B_AUX_INPUT,
    input wire logic       GPIO_LINE_FOUR,
    input wire logic       GPIO_LINE_THREE,
    input wire logic [3:0] TIMER_OUT,
    input wire logic [3:0] TIMEOUT_PULSE,
    input wire logic       IRQ_SOURCE_FOUR,
    input wire logic       IRQ_SOURCE_THREE
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************
    // shadow of bus-written mode state
    // ****************
    logic [7:0] a_mode_reg;
    logic [7:0] cd_mode_reg;
    logic       edge_a_reg;
    logic       a_pulse;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            a_mode_reg <= 8'h00;
            cd_mode_reg <= 8'h00;
            edge_a_reg <= 1'b0;
        end else if (WR) begin
            if (ADDR == qtm_pkg::ADDR_TIMER_A_MODE) a_mode_reg <= WDATA;
            if (ADDR == qtm_pkg::ADDR_TIMER_CD_MODE) cd_mode_reg <= WDATA;
            if (ADDR == qtm_pkg::ADDR_EDGE_SELECT) edge_a_reg <= WDATA[qtm_pkg::EDGE_BIT_A];
        end
    end
    assign a_pulse = a_mode_reg[3] && (a_mode_reg[2:0] != 3'h0);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // ****************
    // assertions
    // ****************
    sequence c_stop_load_s;
        WR && ADDR == qtm_pkg::ADDR_TIMER_C_DATA && cd_mode_reg[6:4] == 3'h0
        ##1 RD && ADDR == qtm_pkg::ADDR_TIMER_C_DATA;
    endsequence
    // eight cycles covers input sync plus the count-to-pulse pipeline
    sequence a_gated_s;
        (a_pulse && TIMER_A_AUX_INPUT != edge_a_reg) [*8];
    endsequence

    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data seen outside the read slot");
    stop_load_a: assert property (c_stop_load_s |=> RDATA == $past(WDATA, 2))
        else $error("stopped timer did not load written count");
    out_toggle_a: assert property ((TIMER_OUT ^ $past(TIMER_OUT)) == TIMEOUT_PULSE)
        else $error("output changed without a time-out");
    pulse_spacing_a: assert property (TIMEOUT_PULSE[0] |=> !TIMEOUT_PULSE[0] [*3])
        else $error("time-outs closer than the smallest divisor");
    stop_quiet_a: assert property ((cd_mode_reg[2:0] == 3'h0) [*4] |-> !TIMEOUT_PULSE[3])
        else $error("stopped timer produced a time-out");
    gate_hold_a: assert property (a_gated_s |-> !TIMEOUT_PULSE[0])
        else $error("gated timer kept counting");
    irq_pulse_a: assert property (
        (a_pulse && $stable(TIMER_A_AUX_INPUT) && $stable(edge_a_reg)) [*6]
        |-> IRQ_SOURCE_FOUR == (TIMER_A_AUX_INPUT ^ edge_a_reg))
        else $error("pulse mode interrupt source wrong");
    irq_normal_a: assert property (
        (!a_pulse && $stable(GPIO_LINE_FOUR) && $stable(edge_a_reg)) [*6]
        |-> IRQ_SOURCE_FOUR == !(GPIO_LINE_FOUR ^ edge_a_reg))
        else $error("normal interrupt source wrong");
endmodule

bind qtm_top qtm_top_props u_qtm_top_props (.CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .TIMER_A_AUX_INPUT, .TIMER_B_AUX_INPUT, .GPIO_LINE_FOUR, .GPIO_LINE_THREE,
    .TIMER_OUT, .TIMEOUT_PULSE, .IRQ_SOURCE_FOUR, .IRQ_SOURCE_THREE);

// ==== dv/qtm_top_tb.sv ====
// self-checking bench for the quad timer block
module qtm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk         = 1'b0;
    logic       rst_n       = 1'b0;
    logic [5:0] addr        = 6'h00;
    logic [7:0] wdata       = 8'h00;
    logic       wr_s        = 1'b0;
    logic       rd_s        = 1'b0;
    logic [1:0] gpio        = 2'b00;
    logic [7:0] rdata;
    logic [1:0] aux;
    logic [3:0] tout;
    logic [3:0] tpulse;
    logic [1:0] irq;
    int         failures    = 0;
    int         n_compared  = 0;
    int         hits [2]    = '{0, 0};
    logic [5:0] mode_ad [2] = '{qtm_pkg::ADDR_TIMER_A_MODE, qtm_pkg::ADDR_TIMER_B_MODE};
    logic [5:0] data_ad [2] = '{qtm_pkg::ADDR_TIMER_A_DATA, qtm_pkg::ADDR_TIMER_B_DATA};
    logic [7:0] ebit [2]    = '{8'h10, 8'h08};
    int         div [8]     = '{0, 4, 10, 16, 50, 64, 100, 200};

    always #5 clk = ~clk;
    always @(posedge clk) begin
        for (int k = 0; k < 2; k++) begin
            if (tpulse[k] === 1'b1) hits[k]++;
        end
    end

    qtm_top u_qtm_top (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
        .RD(rd_s), .RDATA(rdata), .TIMER_A_AUX_INPUT(aux[0]), .TIMER_B_AUX_INPUT(aux[1]),
        .GPIO_LINE_FOUR(gpio[0]), .GPIO_LINE_THREE(gpio[1]), .TIMER_OUT(tout),
        .TIMEOUT_PULSE(tpulse), .IRQ_SOURCE_FOUR(irq[0]), .IRQ_SOURCE_THREE(irq[1]));
    qtm_aux_src u_qtm_aux_src_a (.clk(clk), .line(aux[0]));
    qtm_aux_src u_qtm_aux_src_b (.clk(clk), .line(aux[1]));

    // ****************
    // bus, compare and timing tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask

    // write then read with no gap between the strobes
    task automatic wrrd(input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        wr(a, d);
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 q = rdata;
    endtask

    // cycles from one time-out of timer k to the next
    task automatic gap(input int k, output int n);
        int t;
        t = 0;
        n = 0;
        while (tpulse[k] !== 1'b1 && t < 3000) begin
            @(posedge clk);
            t++;
        end
        do begin
            @(posedge clk);
            n++;
        end while (tpulse[k] !== 1'b1 && n < 3000);
    endtask

    task automatic src(input int k, input int n, input logic v);
        if (k == 0) u_qtm_aux_src_a.drive(n, v, 6);
        else u_qtm_aux_src_b.drive(n, v, 6);
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #500us;
        failures++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        wrap_up();
    end

    // ****************
    // test sequence
    // ****************
    initial begin
        logic [7:0] v;
        logic [7:0] v2;
        logic       o1;
        logic       e;
        int         n;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (data_ad[i]) begin
            rd(data_ad[i], v);
            chk(v, 8'h00);
        end
        rd(6'h3F, v);
        chk(v, 8'h00);
        $display("test reset done");
        for (int s = 1; s < 8; s++) begin
            wr(qtm_pkg::ADDR_TIMER_A_MODE, 8'h00);
            wr(qtm_pkg::ADDR_TIMER_A_DATA, 8'h01);
            wr(qtm_pkg::ADDR_TIMER_A_MODE, 8'(s));
            gap(0, n);
            o1 = tout[0];
            gap(0, n);
            chk(n, div[s]);
            chk(tout[0], !o1);
        end
        rd(qtm_pkg::ADDR_TIMER_A_MODE, v);
        chk(v, 8'h07);
        $display("test divisors done");
        wrrd(qtm_pkg::ADDR_TIMER_C_DATA, 8'h02, v);
        chk(v, 8'h02);
        wr(qtm_pkg::ADDR_TIMER_D_DATA, 8'h00);
        wr(qtm_pkg::ADDR_TIMER_CD_MODE, 8'h11);
        gap(2, n);
        gap(2, n);
        chk(n, 8);
        wr(qtm_pkg::ADDR_TIMER_C_DATA, 8'h05);
        gap(2, n);
        chk(n, 20);
        gap(3, n);
        gap(3, n);
        chk(n, 1024);
        wr(qtm_pkg::ADDR_TIMER_CD_MODE, 8'h00);
        rd(qtm_pkg::ADDR_TIMER_C_DATA, v);
        repeat (40) @(posedge clk);
        rd(qtm_pkg::ADDR_TIMER_C_DATA, v2);
        chk(v2, v);
        $display("test timers c d done");
        for (int k = 0; k < 2; k++) begin
            for (int x = 1; x >= 0; x--) begin
                wr(mode_ad[k], 8'h00);
                src(k, 0, 1'b0);
                wr(qtm_pkg::ADDR_EDGE_SELECT, x ? ebit[k] : 8'h00);
                wr(data_ad[k], 8'h01);
                wr(mode_ad[k], {4'h0, qtm_pkg::MODE_EVENT_COUNT});
                #1 hits[k] = 0;
                src(k, 7, 1'b0);
                repeat (10) @(posedge clk);
                #1 chk(hits[k], x ? 4 : 3);
            end
        end
        $display("test event count done");
        for (int k = 0; k < 2; k++) begin
            e = (k == 0);
            wr(mode_ad[k], 8'h00);
            wr(data_ad[k], 8'h01);
            wr(qtm_pkg::ADDR_EDGE_SELECT, e ? ebit[k] : 8'h00);
            src(k, 0, !e);
            wr(mode_ad[k], 8'h09);
            repeat (10) @(posedge clk);
            #1 hits[k] = 0;
            repeat (60) @(posedge clk);
            #1 chk(hits[k], 0);
            chk(irq[k], 1'b1);
            @(posedge clk);
            gpio[k] <= 1'b1;
            src(k, 0, e);
            repeat (10) @(posedge clk);
            #1 chk(irq[k], 1'b0);
            hits[k] = 0;
            repeat (100) @(posedge clk);
            #1 chk(hits[k], 25);
            src(k, 0, !e);
            repeat (10) @(posedge clk);
            #1 chk(irq[k], 1'b1);
            rd(data_ad[k], v);
            chk(v, 8'h01);
            wr(data_ad[k], 8'h01);
            wr(mode_ad[k], 8'h00);
            repeat (10) @(posedge clk);
            #1 chk(irq[k], !(gpio[k] ^ e));
        end
        $display("test pulse width done");
        wrap_up();
    end
endmodule

// ==== rtl/qtm_channel.sv ====
// one prescaler and 8-bit down counter with reload, toggle output and time-out
module qtm_channel #(
    parameter int PRESCALE_W = qtm_pkg::PRESCALE_W
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire qtm_pkg::qtm_cfg_t cfg,
    input  wire logic             gate,
    input  wire logic             event_pulse,
    input  wire logic             data_wr,
    input  wire logic [7:0]       data_in,
    input  wire logic             out_clear,
    output qtm_pkg::qtm_stat_t    stat,
    output logic                  out_level
);

    if (PRESCALE_W < $clog2(qtm_pkg::PRESCALE_MAX + 1)) begin : g_width_check
        $error("prescaler width too small");
    end

    logic [PRESCALE_W-1:0] pre_reg;
    logic [7:0]            count_reg;
    logic [7:0]            reload_reg;
    logic                  timeout_reg;
    logic                  count_pulse;
    logic                  running;
    logic                  pre_hit;

    assign running = (cfg.mode != qtm_pkg::QTM_STOP);
    // a prescaler select change leaves pre_reg anywhere below 200, hence the odd first interval
    assign pre_hit = (pre_reg >= cfg.divide - PRESCALE_W'(1));

    always_comb begin
        case (cfg.mode)
            qtm_pkg::QTM_DELAY: count_pulse = pre_hit;
            qtm_pkg::QTM_PULSE: count_pulse = gate && pre_hit;
            qtm_pkg::QTM_EVENT: count_pulse = event_pulse;
            default:            count_pulse = 1'b0;
        endcase
    end

    // ****************************************************************
    // prescaler
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_reg <= '0;
        end else if (!running || cfg.mode == qtm_pkg::QTM_EVENT) begin
            pre_reg <= '0;
        end else if (cfg.mode == qtm_pkg::QTM_PULSE && !gate) begin
            pre_reg <= pre_reg;
        end else if (pre_hit) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + PRESCALE_W'(1);
        end
    end

    // ****************************************************************
    // main counter
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reload_reg <= qtm_pkg::RESET_BYTE;
        end else if (data_wr) begin
            reload_reg <= data_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= qtm_pkg::RESET_BYTE;
        end else if (data_wr && !running) begin
            count_reg <= data_in;
        end else if (count_pulse && count_reg == qtm_pkg::COUNT_THROUGH) begin
            // a write in this very cycle wins, one defined value instead of garbage
            count_reg <= data_wr ? data_in : reload_reg;
        end else if (count_pulse) begin
            count_reg <= count_reg - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timeout_reg <= 1'b0;
        end else begin
            timeout_reg <= count_pulse && count_reg == qtm_pkg::COUNT_THROUGH;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_level <= 1'b0;
        end else if (out_clear) begin
            out_level <= 1'b0;
        end else if (count_pulse && count_reg == qtm_pkg::COUNT_THROUGH) begin
            out_level <= ~out_level;
        end
    end

    assign stat.timeout = timeout_reg;
    assign stat.count   = count_reg;

endmodule

// ==== rtl/qtm_pkg.sv ====
// package of register offsets, mode codes and timing constants for the quad timer
package qtm_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [5:0] ADDR_EDGE_SELECT   = 6'h03;
    localparam logic [5:0] ADDR_TIMER_A_MODE  = 6'h19;
    localparam logic [5:0] ADDR_TIMER_B_MODE  = 6'h1B;
    localparam logic [5:0] ADDR_TIMER_CD_MODE = 6'h1D;
    localparam logic [5:0] ADDR_TIMER_A_DATA  = 6'h1F;
    localparam logic [5:0] ADDR_TIMER_B_DATA  = 6'h21;
    localparam logic [5:0] ADDR_TIMER_C_DATA  = 6'h23;
    localparam logic [5:0] ADDR_TIMER_D_DATA  = 6'h25;
    localparam logic [5:0] ADDR_AUX_STATUS    = 6'h27;

    localparam logic [7:0] RESET_BYTE    = 8'h00;
    localparam logic [7:0] COUNT_THROUGH = 8'h01;
    localparam int         EDGE_BIT_A    = 4;
    localparam int         EDGE_BIT_B    = 3;
    localparam int         OUT_RESET_BIT = 4;
    localparam int         CD_C_LSB      = 4;

    // ****************************************************************
    // mode field and prescaler
    // ****************************************************************
    localparam logic [3:0] MODE_STOPPED     = 4'h0;
    localparam logic [3:0] MODE_EVENT_COUNT = 4'h8;
    localparam int         PRESCALE_W       = 8;
    localparam int         PRESCALE_MAX     = 200;

    typedef enum logic [1:0] {
        QTM_STOP,
        QTM_DELAY,
        QTM_EVENT,
        QTM_PULSE
    } qtm_mode_t;

    typedef struct packed {
        qtm_mode_t                 mode;
        logic [PRESCALE_W-1:0]     divide;
    } qtm_cfg_t;

    typedef struct packed {
        logic       timeout;
        logic [7:0] count;
    } qtm_stat_t;

    // divisor for a three-bit prescaler select; zero gives a zero divisor, used for stopped and event count
    function automatic logic [PRESCALE_W-1:0] qtm_divisor(input logic [2:0] sel);
        case (sel)
            3'h1:    qtm_divisor = 8'h04;
            3'h2:    qtm_divisor = 8'h0A;
            3'h3:    qtm_divisor = 8'h10;
            3'h4:    qtm_divisor = 8'h32;
            3'h5:    qtm_divisor = 8'h40;
            3'h6:    qtm_divisor = 8'h64;
            3'h7:    qtm_divisor = 8'hC8;
            default: qtm_divisor = 8'h00;
        endcase
    endfunction

    // four-bit mode field decode of the full-function timers
    function automatic qtm_cfg_t qtm_decode(input logic [3:0] field);
        qtm_cfg_t c;
        c.divide = qtm_divisor(field[2:0]);
        if (field == MODE_STOPPED) begin
            c.mode = QTM_STOP;
        end else if (field == MODE_EVENT_COUNT) begin
            c.mode = QTM_EVENT;
        end else if (field[3]) begin
            c.mode = QTM_PULSE;
        end else begin
            c.mode = QTM_DELAY;
        end
        qtm_decode = c;
    endfunction

endpackage

// ==== rtl/qtm_top.sv ====
// quad 8-bit prescaler timer block with delay, pulse width and event count modes
// ****************************************************************
// ****************************************************************
module qtm_top (
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic [5:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       TIMER_A_AUX_INPUT,
    input  wire logic       TIMER_B_AUX_INPUT,
    input  wire logic       GPIO_LINE_FOUR,
    input  wire logic       GPIO_LINE_THREE,
    output logic      [3:0] TIMER_OUT,
    output logic      [3:0] TIMEOUT_PULSE,
    output logic            IRQ_SOURCE_FOUR,
    output logic            IRQ_SOURCE_THREE
);

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0] edge_select_register_reg;
    logic [7:0] mode_a_reg;
    logic [7:0] mode_b_reg;
    logic [7:0] mode_cd_reg;
    logic [7:0] rdata_reg;
    logic [3:0] out_clear_reg;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            edge_select_register_reg <= qtm_pkg::RESET_BYTE;
            mode_a_reg               <= qtm_pkg::RESET_BYTE;
            mode_b_reg               <= qtm_pkg::RESET_BYTE;
            mode_cd_reg              <= qtm_pkg::RESET_BYTE;
        end else if (WR) begin
            case (ADDR)
                qtm_pkg::ADDR_EDGE_SELECT:   edge_select_register_reg <= WDATA;
                qtm_pkg::ADDR_TIMER_A_MODE:  mode_a_reg  <= {4'h0, WDATA[3:0]};
                qtm_pkg::ADDR_TIMER_B_MODE:  mode_b_reg  <= {4'h0, WDATA[3:0]};
                qtm_pkg::ADDR_TIMER_CD_MODE: mode_cd_reg <= {1'b0, WDATA[6:4], 1'b0, WDATA[2:0]};
                default: ;
            endcase
        end
    end

    // output force-low bit is registered and acts for one cycle only, the cycle after the write
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            out_clear_reg <= 4'h0;
        end else begin
            out_clear_reg[0] <= WR && ADDR == qtm_pkg::ADDR_TIMER_A_MODE
                                && WDATA[qtm_pkg::OUT_RESET_BIT];
            out_clear_reg[1] <= WR && ADDR == qtm_pkg::ADDR_TIMER_B_MODE
                                && WDATA[qtm_pkg::OUT_RESET_BIT];
            out_clear_reg[3:2] <= 2'b00;
        end
    end

    // ****************************************************************
    // configuration decode
    // ****************************************************************
    qtm_pkg::qtm_cfg_t cfg [4];

    always_comb begin
        cfg[0] = qtm_pkg::qtm_decode(mode_a_reg[3:0]);
        cfg[1] = qtm_pkg::qtm_decode(mode_b_reg[3:0]);
        cfg[2].mode   = (mode_cd_reg[6:4] == 3'h0) ? qtm_pkg::QTM_STOP : qtm_pkg::QTM_DELAY;
        cfg[2].divide = qtm_pkg::qtm_divisor(mode_cd_reg[6:4]);
        cfg[3].mode   = (mode_cd_reg[2:0] == 3'h0) ? qtm_pkg::QTM_STOP : qtm_pkg::QTM_DELAY;
        cfg[3].divide = qtm_pkg::qtm_divisor(mode_cd_reg[2:0]);
    end

    // ****************************************************************
    // aux input synchroniser and edge detect
    // ****************************************************************
    logic [1:0] aux_meta_reg;
    logic [1:0] aux_sync_reg;
    logic [1:0] aux_last_reg;
    logic [1:0] edge_bit;
    logic [1:0] active_lvl;
    logic [1:0] last_active;
    logic [1:0] gate;
    logic [1:0] event_pulse;
    logic [1:0] edge_bit_last_reg;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            aux_meta_reg <= 2'b00;
            aux_sync_reg <= 2'b00;
            aux_last_reg <= 2'b00;
        end else begin
            aux_meta_reg <= {TIMER_B_AUX_INPUT, TIMER_A_AUX_INPUT};
            aux_sync_reg <= aux_meta_reg;
            aux_last_reg <= aux_sync_reg;
        end
    end

    assign edge_bit = {edge_select_register_reg[qtm_pkg::EDGE_BIT_B],
                       edge_select_register_reg[qtm_pkg::EDGE_BIT_A]};
    // xor with the edge bit: flipping that bit can itself look like an edge
    assign active_lvl  = ~(aux_sync_reg ^ edge_bit);
    assign last_active = ~(aux_last_reg ^ edge_bit_last_reg);
    assign gate        = active_lvl;
    assign event_pulse = active_lvl & ~last_active;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            edge_bit_last_reg <= 2'b00;
        end else begin
            edge_bit_last_reg <= edge_bit;
        end
    end

    // ****************************************************************
    // timer channels
    // ****************************************************************
    qtm_pkg::qtm_stat_t stat [4];
    logic [3:0]         out_level;
    logic [3:0]         data_wr;

    assign data_wr[0] = WR && ADDR == qtm_pkg::ADDR_TIMER_A_DATA;
    assign data_wr[1] = WR && ADDR == qtm_pkg::ADDR_TIMER_B_DATA;
    assign data_wr[2] = WR && ADDR == qtm_pkg::ADDR_TIMER_C_DATA;
    assign data_wr[3] = WR && ADDR == qtm_pkg::ADDR_TIMER_D_DATA;

    for (genvar i = 0; i < 4; i++) begin : g_ch
        qtm_channel #(
            .PRESCALE_W (qtm_pkg::PRESCALE_W)
        ) u_ch (
            .clk         (CLK),
            .rst_n       (RST_N),
            .cfg         (cfg[i]),
            .gate        ((i < 2) ? gate[i % 2] : 1'b0),
            .event_pulse ((i < 2) ? event_pulse[i % 2] : 1'b0),
            .data_wr     (data_wr[i]),
            .data_in     (WDATA),
            .out_clear   (out_clear_reg[i]),
            .stat        (stat[i]),
            .out_level   (out_level[i])
        );
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            TIMER_OUT     <= 4'h0;
            TIMEOUT_PULSE <= 4'h0;
        end else begin
            TIMER_OUT     <= out_level;
            TIMEOUT_PULSE <= {stat[3].timeout, stat[2].timeout,
                              stat[1].timeout, stat[0].timeout};
        end
    end

    // ****************************************************************
    // interrupt source selection for lines four and three
    // ****************************************************************
    logic pw_a;
    logic pw_b;
    logic src_four;
    logic src_three;

    assign pw_a = (cfg[0].mode == qtm_pkg::QTM_PULSE);
    assign pw_b = (cfg[1].mode == qtm_pkg::QTM_PULSE);
    // normal path presents line ^ ~edge so the controller's rising detect sees the chosen edge;
    // pulse width inverts the sense so the interrupt marks the pulse end
    assign src_four  = pw_a ? ~active_lvl[0]
                            : ~(GPIO_LINE_FOUR ^ edge_bit[0]);
    assign src_three = pw_b ? ~active_lvl[1]
                            : ~(GPIO_LINE_THREE ^ edge_bit[1]);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            IRQ_SOURCE_FOUR  <= 1'b0;
            IRQ_SOURCE_THREE <= 1'b0;
        end else begin
            IRQ_SOURCE_FOUR  <= src_four;
            IRQ_SOURCE_THREE <= src_three;
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    logic [7:0] read_mux;

    // counter sampled at the read strobe, shown the next cycle
    always_comb begin
        case (ADDR)
            qtm_pkg::ADDR_EDGE_SELECT:   read_mux = edge_select_register_reg;
            qtm_pkg::ADDR_TIMER_A_MODE:  read_mux = mode_a_reg;
            qtm_pkg::ADDR_TIMER_B_MODE:  read_mux = mode_b_reg;
            qtm_pkg::ADDR_TIMER_CD_MODE: read_mux = mode_cd_reg;
            qtm_pkg::ADDR_TIMER_A_DATA:  read_mux = stat[0].count;
            qtm_pkg::ADDR_TIMER_B_DATA:  read_mux = stat[1].count;
            qtm_pkg::ADDR_TIMER_C_DATA:  read_mux = stat[2].count;
            qtm_pkg::ADDR_TIMER_D_DATA:  read_mux = stat[3].count;
            qtm_pkg::ADDR_AUX_STATUS:    read_mux = {6'h00, aux_sync_reg};
            default:                     read_mux = qtm_pkg::RESET_BYTE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rdata_reg <= qtm_pkg::RESET_BYTE;
        end else if (RD) begin
            rdata_reg <= read_mux;
        end else begin
            rdata_reg <= qtm_pkg::RESET_BYTE;
        end
    end

    assign RDATA = rdata_reg;

endmodule
